//--- ioibt_map.vh
// Constants for the I/O interrupt and block transfer sequencer.
// Assumes a 16-bit word memory with a one-request handshake.
`ifndef IOIBT_MAP_VH
`define IOIBT_MAP_VH
`define IOIBT_TABLE_PTR_ADDR 16'h0000
`define IOIBT_INDIRECT_TRAP_ADDR 16'h0002
`define IOIBT_UNIMPL_TRAP_ADDR 16'h0003
`define IOIBT_GROUP_SHIFT 2
`define IOIBT_DESC_SHIFT 1
`define IOIBT_WORD1_OFS 16'h0000
`define IOIBT_WORD3_OFS 16'h0002
`define IOIBT_WORD4_OFS 16'h0003
`define IOIBT_DESC_LAST_OFS 16'h0001
`define IOIBT_CALL_OP 6'h08
`define IOIBT_SHORT_SUBROUTINE_CALL_OP 6'h09
`define IOIBT_ENABLE_INSTR 16'h8802
`define IOIBT_ENABLE_OVF_INSTR 16'h8803
`define IOIBT_DISABLE_INSTR 16'h8800
`define IOIBT_DISABLE_OVF_INSTR 16'h8801
`define IOIBT_UNIMPL_LO 16'h0108
`define IOIBT_UNIMPL_HI 16'h01FF
`define IOIBT_NDEV 64
`define IOIBT_DEV_W 6
`endif

//--- ioibt_core.v
// Interrupt vectoring and block transfer sequencer for the processor side of the I/O bus.
// Assumes the instruction unit reports each instruction boundary and a memory port
// that acknowledges each request with mem_ack; devices hold requests until serviced.
// Notes on behaviour
// [R1] Each block transfer is bounded by a first-address and a last-address word.
// [R2] Descriptor pair for device n sits at words 2n and 2n+1.
// [R3] Each device request moves one word; after the last word an interrupt is raised.
// [R4] Descriptor words are re-read from memory for every word moved.
// [R5] A per-device option suppresses the completion interrupt.
// [R6] Optional register descriptors skip the memory descriptor reads.
// [R7] Device completion requests enter the interrupt logic as pending requests.
// [R8] Word zero holds the interrupt table interrupt_table_a; four words per device.
// [R9] A device group sits at interrupt_table_a plus four times the device number.
// [R10] Interrupt accepted only while armed; acceptance clears the arm flag at once.
// [R11] Interrupts wait for instruction end; calls and arm allow one more instruction.
// [R12] The program counter is written into the third word of the group.
// [R13] Word one gets the arm or arm-with-overflow instruction per overflow state.
// [R14] The short instruction in word four is then handed for execution.
// [R15] Indirect address trap executes the instruction at word two.
// [R16] Opcodes in the unimplemented range execute the instruction at word three.
// [R17] The arm instruction sets arm and clears overflow, deferring one instruction.
// [R18] Disarm clears arm; both forms clear or set overflow by their low bit.
// [R19] Simultaneous requests are served lowest device number first.
`include "ioibt_map.vh"
module ioibt_core (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        clk_en,
  input  wire [63:0] dev_irq_req,
  input  wire [63:0] dev_xfer_req,
  input  wire [63:0] dev_xfer_en,
  input  wire [63:0] dev_xfer_noirq,
  input  wire [63:0] dev_dma_regs,
  input  wire        dev_xfer_dir_in,
  input  wire [15:0] dev_data_in,
  input  wire [15:0] dma_first,
  input  wire [15:0] dma_last,
  input  wire        instr_done,
  input  wire [15:0] instr_code,
  input  wire [15:0] pc_value,
  input  wire        ovf_in,
  input  wire        indirect_trap,
  input  wire        mem_ack,
  input  wire [15:0] mem_rdata,
  output reg         mem_req,
  output reg         mem_we,
  output reg  [15:0] mem_addr,
  output reg  [15:0] mem_wdata,
  output reg  [63:0] xfer_ack,
  output reg  [15:0] dev_data_out,
  output reg         dev_data_valid,
  output reg  [63:0] irq_ack,
  output reg         arm_flag,
  output reg         ovf_out,
  output reg         exec_valid,
  output reg  [15:0] exec_instr,
  output wire        cpu_hold
);
  localparam S_IDLE  = 10'b0000000001;
  localparam S_DF    = 10'b0000000010;
  localparam S_DL    = 10'b0000000100;
  localparam S_DATA  = 10'b0000001000;
  localparam S_DWB   = 10'b0000010000;
  localparam S_INTERRUPT_TABLE_A  = 10'b0000100000;
  localparam S_WPC   = 10'b0001000000;
  localparam S_WARM  = 10'b0010000000;
  localparam S_W4    = 10'b0100000000;
  localparam S_TRAP  = 10'b1000000000;

  reg [9:0]  state_q;
  reg [63:0] pend_q;
  reg [5:0]  dev_q;
  reg [15:0] first_q;
  reg [15:0] last_q;
  reg [15:0] interrupt_table_a_q;
  reg [15:0] pc_q;
  reg        ovf_q;
  // Set while the write-back of an advanced first-address word is in flight.
  reg        wb_q;
  reg        din_q;
  wire [63:0] irq_sync;
  wire [63:0] xr_sync;
  wire [63:0] en_sync;
  wire [63:0] noirq_sync;
  wire [63:0] dmar_sync;

  // Device levels come from other controllers, so each bit passes two flip-flops.
  // A transfer request is masked as soon as it is acknowledged, so one request
  // cannot be taken twice while the device lowers it.
  genvar g;
  generate
    for (g = 0; g < `IOIBT_NDEV; g = g + 1) begin : g_sync
      reg irq_s1_q;
      reg irq_s2_q;
      reg xr_s1_q;
      reg xr_s2_q;
      reg en_s1_q;
      reg en_s2_q;
      reg noirq_s1_q;
      reg noirq_s2_q;
      reg dmar_s1_q;
      reg dmar_s2_q;
      always @(posedge clk_sys) begin
        if (rst) begin
          irq_s1_q <= 1'b0;
          irq_s2_q <= 1'b0;
          xr_s1_q <= 1'b0;
          xr_s2_q <= 1'b0;
          en_s1_q <= 1'b0;
          en_s2_q <= 1'b0;
          noirq_s1_q <= 1'b0;
          noirq_s2_q <= 1'b0;
          dmar_s1_q <= 1'b0;
          dmar_s2_q <= 1'b0;
        end else if (clk_en) begin
          irq_s1_q <= dev_irq_req[g];
          irq_s2_q <= irq_s1_q;
          xr_s1_q <= dev_xfer_req[g] & ~xfer_ack[g];
          xr_s2_q <= xr_s1_q & ~xfer_ack[g];
          en_s1_q <= dev_xfer_en[g];
          en_s2_q <= en_s1_q;
          noirq_s1_q <= dev_xfer_noirq[g];
          noirq_s2_q <= noirq_s1_q;
          dmar_s1_q <= dev_dma_regs[g];
          dmar_s2_q <= dmar_s1_q;
        end
      end
      assign irq_sync[g]   = irq_s2_q;
      assign xr_sync[g]    = xr_s2_q;
      assign en_sync[g]    = en_s2_q;
      assign noirq_sync[g] = noirq_s2_q;
      assign dmar_sync[g]  = dmar_s2_q;
    end
  endgenerate

  // Priority encoder: lowest set bit wins.
  function [6:0] lowest;
    input [63:0] v;
    integer i;
    begin
      lowest = 7'h40;
      for (i = 63; i >= 0; i = i - 1) begin
        if (v[i]) begin
          lowest = i[6:0];
        end
      end
    end
  endfunction

  // Compares a finished instruction with an encoding, ignoring its overflow bit.
  function op_match;
    input [15:0] code;
    input [15:0] pattern;
    begin
      op_match = (code[15:1] == pattern[15:1]);
    end
  endfunction

  // Address of the first-address descriptor word of a device.
  function [15:0] desc_word;
    input [5:0] dev;
    begin
      desc_word = {9'h000, dev, 1'b0};
    end
  endfunction

  // Address of a word within the four-word interrupt group of a device.
  function [15:0] group_word;
    input [15:0] interrupt_table_a;
    input [5:0]  dev;
    input [15:0] ofs;
    begin
      group_word = interrupt_table_a + {8'h00, dev, 2'b00} + ofs;
    end
  endfunction

  wire [6:0]  irq_pick  = lowest(pend_q);
  wire [6:0]  xfer_pick = lowest(xr_sync & en_sync);
  wire        is_call   = (instr_code[15:10] == `IOIBT_CALL_OP) |
                          (instr_code[15:10] == `IOIBT_SHORT_SUBROUTINE_CALL_OP);
  wire        is_arm    = op_match(instr_code, `IOIBT_ENABLE_INSTR);
  wire        is_disarm = op_match(instr_code, `IOIBT_DISABLE_INSTR);
  // Calls and the arm instruction let one more instruction run first.
  wire        no_defer  = ~is_call & ~is_arm;
  wire        is_unimpl = (instr_code >= `IOIBT_UNIMPL_LO) & (instr_code <= `IOIBT_UNIMPL_HI);
  wire [15:0] desc_addr = desc_word(dev_q);
  wire [15:0] grp_interrupt_table_a  = group_word(interrupt_table_a_q, dev_q, 16'h0000);
  wire [15:0] nxt_first = first_q + 16'h0001;

  assign cpu_hold = ~state_q[0];

  always @(posedge clk_sys) begin
    if (rst) begin
      state_q <= S_IDLE;
      pend_q <= 64'h0;
      dev_q <= 6'h00;
      first_q <= 16'h0000;
      last_q <= 16'h0000;
      interrupt_table_a_q <= 16'h0000;
      pc_q <= 16'h0000;
      ovf_q <= 1'b0;
      wb_q <= 1'b0;
      din_q <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
      xfer_ack <= 64'h0;
      irq_ack <= 64'h0;
      dev_data_out <= 16'h0000;
      dev_data_valid <= 1'b0;
      arm_flag <= 1'b0;
      ovf_out <= 1'b0;
      exec_valid <= 1'b0;
      exec_instr <= 16'h0000;
    end else if (clk_en) begin
      xfer_ack <= 64'h0;
      irq_ack  <= 64'h0;
      dev_data_valid <= 1'b0;
      exec_valid <= 1'b0;
      pend_q <= (pend_q | irq_sync) & ~irq_ack; // [R7]
      case (state_q)
        S_IDLE: begin
          if (instr_done) begin
            if (is_arm | is_disarm) begin
              arm_flag <= is_arm; // [R17] [R18]
              ovf_out  <= instr_code[0];
            end else begin
              ovf_out <= ovf_in;
            end
          end
          // Block transfers go first, then traps, then interrupts.
          if (xfer_pick[6] == 1'b0) begin
            dev_q <= xfer_pick[5:0];
            din_q <= dev_xfer_dir_in;
            xfer_ack[xfer_pick[5:0]] <= 1'b1;
            if (dmar_sync[xfer_pick[5:0]]) begin
              first_q <= dma_first; // [R6]
              last_q <= dma_last;
              state_q <= S_DATA;
            end else begin
              mem_req <= 1'b1;
              mem_we <= 1'b0;
              mem_addr <= desc_word(xfer_pick[5:0]); // [R2] [R4]
              state_q <= S_DF;
            end
          end else if (indirect_trap) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= `IOIBT_INDIRECT_TRAP_ADDR; // [R15]
            state_q <= S_TRAP;
          end else if (instr_done & is_unimpl) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= `IOIBT_UNIMPL_TRAP_ADDR; // [R16]
            state_q <= S_TRAP;
          end else if (instr_done & no_defer & arm_flag & ~irq_pick[6]) begin // [R11]
            arm_flag <= 1'b0; // [R10]
            dev_q <= irq_pick[5:0]; // [R19]
            irq_ack[irq_pick[5:0]] <= 1'b1;
            pc_q <= pc_value;
            ovf_q <= ovf_in;
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= `IOIBT_TABLE_PTR_ADDR; // [R8]
            state_q <= S_INTERRUPT_TABLE_A;
          end
        end
        S_DF: if (mem_ack) begin
          first_q <= mem_rdata; // [R1]
          mem_addr <= desc_addr + `IOIBT_DESC_LAST_OFS;
          state_q <= S_DL;
        end
        S_DL: if (mem_ack) begin
          last_q <= mem_rdata; // [R1]
          mem_req <= 1'b0;
          state_q <= S_DATA;
        end
        S_DATA: begin
          mem_req <= 1'b1;
          mem_we <= din_q;
          mem_addr <= first_q;
          mem_wdata <= dev_data_in;
          state_q <= S_DWB;
        end
        // The block ends on the last word; register descriptors need no write-back.
        S_DWB: if (mem_ack) begin
          if (~din_q) begin
            dev_data_out <= mem_rdata; // [R3]
            dev_data_valid <= 1'b1;
          end
          if (first_q == last_q) begin
            if (~noirq_sync[dev_q]) begin
              pend_q[dev_q] <= 1'b1; // [R3] [R5]
            end
            mem_req <= 1'b0;
            state_q <= S_IDLE;
          end else if (dmar_sync[dev_q]) begin
            mem_req <= 1'b0;
            state_q <= S_IDLE;
          end else begin
            mem_we <= 1'b1; // [R4]
            mem_addr <= desc_addr;
            mem_wdata <= nxt_first;
            first_q <= nxt_first;
            state_q <= S_WARM;
            wb_q <= 1'b1;
          end
        end
        S_INTERRUPT_TABLE_A: if (mem_ack) begin
          interrupt_table_a_q <= mem_rdata;
          mem_we <= 1'b1;
          mem_addr <= group_word(mem_rdata, dev_q, `IOIBT_WORD3_OFS); // [R9]
          mem_wdata <= pc_q; // [R12]
          state_q <= S_WPC;
        end
        S_WPC: if (mem_ack) begin
          mem_addr <= grp_interrupt_table_a + `IOIBT_WORD1_OFS;
          mem_wdata <= ovf_q ? `IOIBT_ENABLE_OVF_INSTR : `IOIBT_ENABLE_INSTR; // [R13]
          state_q <= S_WARM;
        end
        S_WARM: if (mem_ack) begin
          // This state serves both the descriptor write-back and the arm-word write.
          if (wb_q) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            wb_q <= 1'b0;
            state_q <= S_IDLE;
          end else begin
            mem_we <= 1'b0;
            mem_addr <= grp_interrupt_table_a + `IOIBT_WORD4_OFS; // [R14]
            state_q <= S_W4;
          end
        end
        S_W4, S_TRAP: if (mem_ack) begin
          mem_req <= 1'b0;
          exec_instr <= mem_rdata; // [R14]
          exec_valid <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule

//--- ioibt_core_asserts.sv
// Checker for the interrupt and block transfer sequencer.
// Assumes one clock domain and that it is bound to the sequencer top.
module ioibt_core_asserts (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic        instr_done,
  input wire logic [15:0] instr_code,
  input wire logic        indirect_trap,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic        mem_ack,
  input wire logic [15:0] mem_addr,
  input wire logic [63:0] irq_ack,
  input wire logic [63:0] xfer_ack,
  input wire logic        arm_flag,
  input wire logic        ovf_out,
  input wire logic        cpu_hold
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_tbl_read;
    mem_req && !mem_we && mem_addr == 16'h0000;
  endsequence
  property p_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  property p_arm;
    clk_en && instr_done && instr_code == 16'h8802 && !cpu_hold |=> arm_flag && !ovf_out;
  endproperty
  property p_disarm;
    clk_en && instr_done && instr_code == 16'h8800 && !cpu_hold |=> !arm_flag && !ovf_out;
  endproperty
  property p_acc;
    (|irq_ack) |-> !arm_flag && $past(arm_flag);
  endproperty
  property p_irq1;
    $onehot0(irq_ack);
  endproperty
  property p_xfer1;
    $onehot0(xfer_ack);
  endproperty
  property p_tbl;
    (|irq_ack) |-> ##[0:4] s_tbl_read;
  endproperty
  property p_trap;
    clk_en && indirect_trap && !cpu_hold |-> ##[1:30] (mem_req && mem_addr == 16'h0002);
  endproperty
  a_hold: assert property (p_hold) else $error("memory request changed before ack");
  a_arm: assert property (p_arm) else $error("arm did not set flag");
  a_disarm: assert property (p_disarm) else $error("disarm did not clear flag");
  a_acc: assert property (p_acc) else $error("interrupt accepted while unarmed");
  a_irq1: assert property (p_irq1) else $error("several interrupts accepted");
  a_xfer1: assert property (p_xfer1) else $error("several transfer acks");
  a_tbl: assert property (p_tbl) else $error("table pointer not read");
  a_trap: assert property (p_trap) else $error("trap word not fetched");
endmodule
bind ioibt_core ioibt_core_asserts chk (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
  .instr_done(instr_done), .instr_code(instr_code), .indirect_trap(indirect_trap),
  .mem_req(mem_req), .mem_we(mem_we), .mem_ack(mem_ack), .mem_addr(mem_addr),
  .irq_ack(irq_ack), .xfer_ack(xfer_ack), .arm_flag(arm_flag), .ovf_out(ovf_out),
  .cpu_hold(cpu_hold));

//--- ioibt_mem_model.sv
// Word memory answering the sequencer's request port.
// Acks after a varying wait; read data scrambles when not acked.
module ioibt_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic             mem_ack,
  output logic [15:0]      mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:255];
  logic [1:0]  dly = 2'h0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 16'h0000;
  always @(posedge clk_sys) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (dly == 2'h0) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem[mem_addr[7:0]];
        if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
      end
      dly <= dly + 2'h1;
    end
  end
endmodule

//--- ioibt_core_bench.sv
// Self-checking bench for the sequencer with a memory model.
// Assumes the checker is bound to the sequencer.
module ioibt_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rst = 1, instr_done = 0, ovf_in = 0, indirect_trap = 0, dev_xfer_dir_in = 0;
  logic [63:0] dev_irq_req = 0, dev_xfer_req = 0, dev_xfer_en = 0, dev_xfer_noirq = 0;
  logic [63:0] dev_dma_regs = 0;
  logic [15:0] instr_code = 0, pc_value = 16'h0123, dma_first = 0, dma_last = 0;
  wire mem_req, mem_we, mem_ack, dev_data_valid, arm_flag, ovf_out, exec_valid, cpu_hold;
  wire [15:0] mem_addr, mem_wdata, mem_rdata, dev_data_out, exec_instr;
  wire [63:0] xfer_ack, irq_ack;
  int bad_count = 0, num_checks = 0, cyc = 0;
  ioibt_core uut (.clk_sys, .rst, .clk_en(1'b1), .dev_irq_req, .dev_xfer_req, .dev_xfer_en,
    .dev_xfer_noirq, .dev_dma_regs, .dev_xfer_dir_in, .dev_data_in(16'h0000),
    .dma_first, .dma_last, .instr_done, .instr_code, .pc_value, .ovf_in,
    .indirect_trap, .mem_ack, .mem_rdata, .mem_req, .mem_we, .mem_addr, .mem_wdata, .xfer_ack,
    .dev_data_out, .dev_data_valid, .irq_ack, .arm_flag, .ovf_out, .exec_valid, .exec_instr,
    .cpu_hold);
  ioibt_mem_model mdl (.clk_sys, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
  initial forever #5 clk_sys = ~clk_sys;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pulse_instr(input logic [15:0] code);
    @(negedge clk_sys) instr_code = code;
    instr_done = 1;
    @(negedge clk_sys) instr_done = 0;
  endtask
  task automatic wait_exec;
    int n;
    n = 0;
    while (!exec_valid && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  task automatic block_xfer;
    int n;
    mdl.mem[4] = 16'h0080;
    mdl.mem[5] = 16'h0081;
    mdl.mem[8'h80] = 16'hA5A5;
    mdl.mem[8'h81] = 16'h5A5A;
    dev_xfer_en[2] = 1;
    dev_xfer_noirq[2] = 1;
    for (int i = 0; i < 2; i++) begin
      n = 0;
      @(negedge clk_sys) dev_xfer_req[2] = 1;
      while (!dev_data_valid && n < 200) begin
        @(negedge clk_sys);
        if (xfer_ack[2]) dev_xfer_req[2] = 0;
        n++;
      end
      chk(dev_data_out, i ? 16'h5A5A : 16'hA5A5);
      repeat (8) @(negedge clk_sys);
      if (i == 0) chk(mdl.mem[4], 16'h0081);
    end
    chk(irq_ack, 64'h0);
  endtask
  task automatic reg_xfer;
    int n;
    mdl.mem[8] = 16'h0080;
    mdl.mem[9] = 16'h0080;
    mdl.mem[8'h90] = 16'h1234;
    dma_first = 16'h0090;
    dma_last = 16'h0090;
    dev_dma_regs[4] = 1;
    dev_xfer_en[4] = 1;
    dev_xfer_noirq[4] = 1;
    n = 0;
    @(negedge clk_sys) dev_xfer_req[4] = 1;
    while (!dev_data_valid && n < 200) begin
      @(negedge clk_sys);
      if (xfer_ack[4]) dev_xfer_req[4] = 0;
      n++;
    end
    chk(dev_data_out, 16'h1234);
    chk(mdl.mem[8], 16'h0080);
  endtask
  task automatic irq_take;
    int n;
    mdl.mem[0] = 16'h0040;
    mdl.mem[8'h4F] = 16'h0053;
    pulse_instr(16'h8800);
    chk(arm_flag, 1'b0);
    pulse_instr(16'h8802);
    chk(arm_flag, 1'b1);
    dev_irq_req[5] = 1;
    dev_irq_req[3] = 1;
    instr_code = 16'h0000;
    n = 0;
    while (irq_ack == 0 && n < 200) begin
      @(negedge clk_sys) instr_done = (n % 4 == 0);
      n++;
    end
    instr_done = 0;
    chk(irq_ack, 64'h8);
    dev_irq_req = 0;
    wait_exec;
    chk(exec_instr, 16'h0053);
    chk(mdl.mem[8'h4E], pc_value);
    chk(mdl.mem[8'h4C], 16'h8802);
    chk(arm_flag, 1'b0);
  endtask
  task automatic traps;
    mdl.mem[2] = 16'h01FF;
    mdl.mem[3] = 16'h016D;
    @(negedge clk_sys) indirect_trap = 1;
    @(negedge clk_sys) indirect_trap = 0;
    wait_exec;
    chk(exec_instr, 16'h01FF);
    repeat (4) @(negedge clk_sys);
    pulse_instr(16'h0108);
    wait_exec;
    chk(exec_instr, 16'h016D);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys) rst = 0;
    block_xfer();
    reg_xfer();
    irq_take();
    traps();
    stop_test();
  end
endmodule
